// File: core/rs_seq_pkg.sv
// shared constants and types for the rolling-shutter trigger sequencer
package rs_seq_pkg;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int unsigned     ROW_CLKS_DEF     = 2624; // other variant: 2592
   localparam int unsigned     FRAME_ROWS_DEF   = 1080;
   localparam longint unsigned CLK_PERIOD_NS    = 40;
   localparam longint unsigned NS_PER_S         = 1_000_000_000;
   localparam longint unsigned EXP_MAX_S        = 30;
   localparam longint unsigned CYC_MAX_S        = 20_000;
   localparam int unsigned     INT_EXP_MIN_ROWS = 1;
   localparam int unsigned     TRG_EXP_MIN_ROWS = 3;
   localparam int unsigned     TRIG_MIN_CLKS    = 2;
   localparam logic [4:0]      GAP_MIN_CLKS     = 5'h14; // 20 clocks of row-1 low time

   // ------------------------------------------------------------------
   // register map and fields
   // ------------------------------------------------------------------
   localparam logic [3:0]  ADDR_CTRL     = 4'h0;
   localparam logic [3:0]  ADDR_EXPOSURE = 4'h1;
   localparam logic [3:0]  ADDR_CYCLE    = 4'h2;
   localparam logic [3:0]  ADDR_STATUS   = 4'h3;
   localparam int unsigned CTRL_RUN      = 0;
   localparam int unsigned CTRL_OVERLAP  = 1;
   localparam int unsigned CTRL_MODE_LO  = 2;
   localparam int unsigned CTRL_SWTRIG   = 4;
   localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
   localparam logic [31:0] EXPOSURE_RST  = 32'h0000_000a;
   localparam logic [31:0] CYCLE_RST     = 32'h0000_0800;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_INTERNAL = 2'h0,
      MODE_EXT      = 2'h1,
      MODE_EXT_EXPO = 2'h2
   } trig_mode_e;

   typedef enum logic [5:0] {
      S_IDLE   = 6'h01,
      S_ARMED  = 6'h02,
      S_EXPOSE = 6'h04,
      S_SIGNAL = 6'h08,
      S_HOLD   = 6'h10,
      S_OVLRUN = 6'h20
   } seq_state_e;

   typedef struct packed {
      logic fireRow1;
      logic fireRowN;
      logic fireAll;
      logic fireAny;
      logic globalClear;
      logic prescan;
      logic discardRead;
      logic signalRead;
      logic trigReady;
   } seq_out_s;

endpackage

// File: core/trig_edge_sync.sv
// external trigger synchroniser with edge detection
`timescale 1ns/100ps
`default_nettype none
module trig_edge_sync
   import rs_seq_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic extTrigger,
   output logic      trigRise,
   output logic      trigFall
);

   logic meta;
   logic stable;
   logic last;
   logic next_meta;
   logic next_stable;
   logic next_last;

   // ------------------------------------------------------------------
   // two-stage sync, third stage only for edges
   // ------------------------------------------------------------------
   always_comb
   begin
      next_meta   = extTrigger;
      next_stable = meta;
      next_last   = stable;
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta   <= 1'b0;
         stable <= 1'b0;
         last   <= 1'b0;
      end
      else
      begin
         meta   <= next_meta;
         stable <= next_stable;
         last   <= next_last;
      end
   end

   // fixed two-clock latency, far below one row
   assign trigRise = stable & ~last; // pulses of two clocks or more are seen
   assign trigFall = ~stable & last;

endmodule
`default_nettype wire

// File: core/rs_trigger_sequencer.sv
// rolling-shutter acquisition and trigger sequencer
// ----------------------------------------------------------------------
// What this block does
// - every-row output high only while first and last rows integrate together
// - some-row output high while any row integrates
// - internal non-overlap: flush held, released, discarded read starts exposure
// - internal non-overlap: signal read after exposure, flush until cycle ends
// - internal non-overlap: exposure 1 row to 30 s, cycle limits, start delay zero
// - internal overlap: next exposure runs during readout
// - overlap short: cycle is one frame, first-row gap at least one row
// - overlap long: exposure sets cycle, first-row gap at least one row
// - overlap long: each row re-exposes as it is read
// - triggered waiting: flush held, prescan reads, trigger-ready high
// - triggered non-overlap: release, discard, expose, signal, flush till trigger
// - triggered: exposure 3 rows to 30 s, start delay zero
// - external exposure: signal read starts at trigger fall
// - external exposure: pulse sets exposure, later rows offset a row each
// - external exposure: falls under three rows are ignored
// - external overlap: each rise reads a frame and starts next exposure
// - external overlap: first rise discards, later rises read signal frames
// - external overlap: first-row low gap at least twenty clocks
// - triggers arriving while trigger-ready is low are ignored
// - first-row output high exactly for the first row's exposure
// - one row is a fixed clock count, 2624 or 2592
// ----------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module rs_trigger_sequencer
   import rs_seq_pkg::*;
#(
   parameter int unsigned ROW_CLKS   = ROW_CLKS_DEF,
   parameter int unsigned FRAME_ROWS = FRAME_ROWS_DEF
)
(
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic [3:0]  regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [31:0] regRdData,
   input  wire logic        extTrigger,
   output seq_out_s         seqOut
);

   // ------------------------------------------------------------------
   // derived limits
   // ------------------------------------------------------------------
   localparam longint unsigned ROW_NS = longint'(ROW_CLKS) * CLK_PERIOD_NS;
   localparam logic [31:0] EXP_MAX_ROWS = 32'((EXP_MAX_S * NS_PER_S) / ROW_NS);
   localparam longint unsigned CYC_MAX_FULL = (CYC_MAX_S * NS_PER_S) / ROW_NS;
   // short rows overflow 32 bits here, so saturate rather than wrap
   localparam logic [31:0] CYC_MAX_ROWS = (CYC_MAX_FULL > 64'h0000_0000_ffff_ffff)
                                          ? 32'hffff_ffff : 32'(CYC_MAX_FULL);
   localparam logic [31:0] FRAME        = 32'(FRAME_ROWS);
   localparam logic [31:0] ROWN_DLY     = 32'((FRAME_ROWS - 1) * ROW_CLKS);
   localparam logic [15:0] ROW_LAST     = 16'(ROW_CLKS - 1);

   if (ROW_CLKS < 2 || ROW_CLKS > 65535 || FRAME_ROWS < 2 || FRAME_ROWS > 65535)
   begin : g_bad_size
      $error("row clock count or frame rows out of range");
   end

   function automatic logic [31:0] clampRows(input logic [31:0] v,
                                             input logic [31:0] lo,
                                             input logic [31:0] hi);
      clampRows = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   seq_state_e  state;
   seq_state_e  next_state;
   logic        run;
   logic        overlap;
   trig_mode_e  mode;
   logic [31:0] exposure;
   logic [31:0] cycle;
   logic [15:0] div;
   logic [31:0] per;
   logic [31:0] readCnt;
   logic        readSig;
   logic [4:0]  gap;
   logic        row1;
   logic        rowN;
   logic        any;
   logic [31:0] riseCnt;
   logic [31:0] fallCnt;
   logic        next_run;
   logic        next_overlap;
   trig_mode_e  next_mode;
   logic [31:0] next_exposure;
   logic [31:0] next_cycle;
   logic [31:0] next_regRdData;
   logic [15:0] next_div;
   logic [31:0] next_per;
   logic [31:0] next_readCnt;
   logic        next_readSig;
   logic [4:0]  next_gap;
   logic        next_row1;
   logic        next_rowN;
   logic        next_any;
   logic [31:0] next_riseCnt;
   logic [31:0] next_fallCnt;
   seq_out_s    next_seqOut;

   logic        trigRise;
   logic        trigFall;
   logic        swTrig;
   logic        trigTake;
   logic        rowTick;
   logic [31:0] perInc;
   logic [31:0] expEff;
   logic [31:0] cycEff;
   logic [31:0] ovlCyc;
   logic        internal;
   logic        extExpo;
   logic        ovl;
   logic        start;
   logic        readGo;
   logic        r1Set;
   logic        r1Clr;
   logic        nSet;
   logic        nClr;

   trig_edge_sync u_sync (
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .extTrigger (extTrigger),
      .trigRise   (trigRise),
      .trigFall   (trigFall)
   );

   // ------------------------------------------------------------------
   // mode decode and timing limits
   // ------------------------------------------------------------------
   assign internal = (mode != MODE_EXT) && (mode != MODE_EXT_EXPO);
   assign extExpo  = (mode == MODE_EXT_EXPO);
   assign ovl      = overlap && (mode != MODE_EXT);
   assign expEff   = clampRows(exposure, (mode == MODE_EXT) ? 32'(TRG_EXP_MIN_ROWS)
                                        : 32'(INT_EXP_MIN_ROWS), EXP_MAX_ROWS);
   assign cycEff   = clampRows(cycle, expEff + FRAME + 32'h1, CYC_MAX_ROWS);
   // short exposures give a frame cycle, long ones exposure plus a gap row
   assign ovlCyc   = (expEff + 32'h1 > FRAME) ? expEff + 32'h1 : FRAME;
   assign rowTick  = (div == ROW_LAST); // one row of clocks
   assign perInc   = per + 32'h1;
   assign swTrig   = regWr && (regAddr == ADDR_CTRL) && regWrData[CTRL_SWTRIG];
   // only a trigger seen while ready is high counts
   assign trigTake = seqOut.trigReady && ((mode == MODE_EXT && (trigRise || swTrig))
                                         || (extExpo && trigRise));

   // ------------------------------------------------------------------
   // sequencer next state
   // ------------------------------------------------------------------
   always_comb
   begin
      next_state   = state;
      next_div     = rowTick ? 16'h0 : div + 16'h1;
      next_per     = rowTick ? perInc : per;
      next_readCnt = (rowTick && readCnt != 32'h0) ? readCnt - 32'h1 : readCnt;
      next_readSig = readSig;
      next_gap     = (gap != 5'h0) ? gap - 5'h1 : gap;
      start        = 1'b0;
      readGo       = 1'b0;
      r1Set        = (gap == 5'h1);
      r1Clr        = 1'b0;
      unique case (state)
         S_IDLE:
         begin
            if (run && internal)
               start = 1'b1; // no start delay
            else if (run)
               next_state = S_ARMED;
         end
         S_ARMED:
         begin
            if (trigTake)
               start = 1'b1; // start delay zero
         end
         S_EXPOSE:
         begin
            // a fall before three rows leaves the exposure running
            if (extExpo ? (trigFall && per >= 32'(TRG_EXP_MIN_ROWS))
                        : (rowTick && perInc == expEff))
            begin
               readGo     = 1'b1;
               r1Clr      = 1'b1; // pulse width is row-1 exposure
               next_state = S_SIGNAL;
            end
         end
         S_SIGNAL:
         begin
            if (rowTick && readCnt == 32'h1)
               next_state = internal ? S_HOLD : S_ARMED;
         end
         S_HOLD:
         begin
            if (rowTick && perInc == cycEff)
               start = 1'b1;
         end
         S_OVLRUN:
         begin
            if (internal && rowTick && perInc == ovlCyc)
            begin
               readGo   = 1'b1; // read while the next exposure runs
               r1Clr    = 1'b1;
               next_per = 32'h0;
            end
            else if (internal && rowTick && perInc == ovlCyc - expEff)
               r1Set = 1'b1;
            else if (!internal && trigTake)
            begin
               readGo   = 1'b1; // every accepted rise reads a frame
               r1Clr    = 1'b1;
               next_gap = GAP_MIN_CLKS;
            end
         end
      endcase
      if (start)
      begin
         next_per     = 32'h0;
         next_readCnt = FRAME; // flush released, discarded frame read
         next_readSig = 1'b0;
         next_state   = ovl ? S_OVLRUN : S_EXPOSE;
         r1Set        = !ovl; // discarded read opens the exposure
         next_gap     = (ovl && extExpo) ? GAP_MIN_CLKS : 5'h0;
      end
      if (readGo)
      begin
         next_readCnt = FRAME;
         next_readSig = 1'b1;
      end
      if (start || readGo)
         next_div = 16'h0; // rows aligned to the read start
      if (!run)
      begin
         next_state   = S_IDLE;
         next_readCnt = 32'h0;
         next_gap     = 5'h0;
         r1Set        = 1'b0;
         r1Clr        = row1;
      end
   end

   // ------------------------------------------------------------------
   // exposure outputs next values
   // ------------------------------------------------------------------
   always_comb
   begin
      next_row1    = r1Set ? 1'b1 : (r1Clr ? 1'b0 : row1);
      nSet         = (riseCnt == 32'h1);
      nClr         = (fallCnt == 32'h1);
      // last row follows row 1 by one row per further row
      next_riseCnt = r1Set ? ROWN_DLY : ((riseCnt != 32'h0) ? riseCnt - 32'h1 : riseCnt);
      next_fallCnt = r1Clr ? ROWN_DLY : ((fallCnt != 32'h0) ? fallCnt - 32'h1 : fallCnt);
      next_rowN    = nSet ? 1'b1 : (nClr ? 1'b0 : rowN);
      // some row is exposing from row-1 start to last-row end
      next_any     = r1Set ? 1'b1 : (nClr ? next_row1 : any);
      if (!run)
      begin
         next_riseCnt = 32'h0;
         next_fallCnt = 32'h0;
         next_rowN    = 1'b0;
         next_any     = 1'b0;
      end
      next_seqOut.fireRow1    = next_row1;
      next_seqOut.fireRowN    = next_rowN;
      next_seqOut.fireAll     = next_row1 && next_rowN;
      next_seqOut.fireAny     = next_any;
      next_seqOut.globalClear = (next_state == S_IDLE) || (next_state == S_ARMED)
                                || (next_state == S_HOLD);
      next_seqOut.prescan     = (next_state == S_ARMED);
      next_seqOut.discardRead = (next_readCnt != 32'h0) && !next_readSig;
      next_seqOut.signalRead  = (next_readCnt != 32'h0) && next_readSig;
      next_seqOut.trigReady   = (next_state == S_ARMED) || ((next_state == S_OVLRUN)
                                && extExpo && next_readCnt == 32'h0);
   end

   // ------------------------------------------------------------------
   // register port next values
   // ------------------------------------------------------------------
   always_comb
   begin
      next_run       = run;
      next_overlap   = overlap;
      next_mode      = mode;
      next_exposure  = exposure;
      next_cycle     = cycle;
      next_regRdData = 32'h0;
      if (regWr && regAddr == ADDR_CTRL)
      begin
         next_run     = regWrData[CTRL_RUN];
         next_overlap = regWrData[CTRL_OVERLAP];
         next_mode    = trig_mode_e'(regWrData[CTRL_MODE_LO +: 2]);
      end
      if (regWr && regAddr == ADDR_EXPOSURE)
         next_exposure = regWrData;
      if (regWr && regAddr == ADDR_CYCLE)
         next_cycle = regWrData;
      if (regRd)
      begin
         unique case (regAddr)
            ADDR_CTRL:     next_regRdData = {28'h0, mode, overlap, run};
            ADDR_EXPOSURE: next_regRdData = exposure;
            ADDR_CYCLE:    next_regRdData = cycle;
            ADDR_STATUS:   next_regRdData = {18'h0, state, 4'h0, seqOut.trigReady,
                                             readCnt != 32'h0, expEff != exposure,
                                             cycEff != cycle};
            default:       next_regRdData = 32'h0;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state     <= S_IDLE;
         run       <= CTRL_RST[CTRL_RUN];
         overlap   <= CTRL_RST[CTRL_OVERLAP];
         mode      <= trig_mode_e'(CTRL_RST[CTRL_MODE_LO +: 2]);
         exposure  <= EXPOSURE_RST;
         cycle     <= CYCLE_RST;
         regRdData <= 32'h0;
         div       <= 16'h0;
         per       <= 32'h0;
         readCnt   <= 32'h0;
         readSig   <= 1'b0;
         gap       <= 5'h0;
         row1      <= 1'b0;
         rowN      <= 1'b0;
         any       <= 1'b0;
         riseCnt   <= 32'h0;
         fallCnt   <= 32'h0;
         seqOut    <= '{globalClear: 1'b1, default: 1'b0};
      end
      else
      begin
         state     <= next_state;
         run       <= next_run;
         overlap   <= next_overlap;
         mode      <= next_mode;
         exposure  <= next_exposure;
         cycle     <= next_cycle;
         regRdData <= next_regRdData;
         div       <= next_div;
         per       <= next_per;
         readCnt   <= next_readCnt;
         readSig   <= next_readSig;
         gap       <= next_gap;
         row1      <= next_row1;
         rowN      <= next_rowN;
         any       <= next_any;
         riseCnt   <= next_riseCnt;
         fallCnt   <= next_fallCnt;
         seqOut    <= next_seqOut;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   logic [4:0] lowCnt;

   // helper: clocks since row-1 output fell, saturating
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         lowCnt <= 5'h0;
      else if (seqOut.fireRow1)
         lowCnt <= 5'h0;
      else if (lowCnt != 5'h1f)
         lowCnt <= lowCnt + 5'h1;
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   a_all_both: assert property (seqOut.fireAll |-> seqOut.fireRow1 && seqOut.fireRowN)
      else $error("every-row output without first and last row exposing");
   a_any_cover: assert property ((seqOut.fireRow1 || seqOut.fireRowN) |-> seqOut.fireAny)
      else $error("some-row output low while a row exposes");
   a_release_discard: assert property ($fell(seqOut.globalClear) |-> seqOut.discardRead)
      else $error("flush released without a discarded read");
   a_hold_flush: assert property (state == S_HOLD |-> seqOut.globalClear && !seqOut.fireRow1)
      else $error("flush not held after signal read");
   a_wait_armed: assert property (state == S_ARMED |-> seqOut.prescan && seqOut.globalClear
                                  && seqOut.trigReady)
      else $error("waiting without flush, prescan or ready");
   a_trig_ready: assert property (trigTake |-> seqOut.trigReady ##1 !seqOut.globalClear)
      else $error("trigger taken while not ready");
   a_short_fall: assert property (state == S_EXPOSE && extExpo && trigFall
                                  && per < 32'h3 && run |=> state == S_EXPOSE)
      else $error("short exposure pulse ended the exposure");
   a_ovl_read: assert property (state == S_OVLRUN && internal && run && rowTick
                                && perInc == ovlCyc |=> seqOut.signalRead
                                && !seqOut.fireRow1 ##1 !seqOut.fireRow1)
      else $error("overlap cycle read missing or gap too short");
   a_ext_gap: assert property ($rose(seqOut.fireRow1) && extExpo && ovl
                               |-> lowCnt >= GAP_MIN_CLKS)
      else $error("first-row low gap under twenty clocks");
   a_exp_range: assert property (expEff >= 32'h1 && expEff <= EXP_MAX_ROWS
                                 && cycEff > expEff + FRAME)
      else $error("effective exposure or cycle out of range");

   c_int_cycle: cover property (state == S_HOLD ##1 state == S_EXPOSE);
   c_ext_trig: cover property (state == S_ARMED ##1 state == S_EXPOSE);
   c_ovl_read: cover property (state == S_OVLRUN && $rose(seqOut.signalRead));
   c_all_rows: cover property ($rose(seqOut.fireAll));

endmodule
`default_nettype wire

// File: tb/trig_source.sv
// external trigger source model
`timescale 1ns/100ps
`default_nettype none
module trig_source
(
   input  wire logic ref_clk,
   output logic      extTrigger
);
   // idle low until a pulse is asked for
   initial extTrigger = 1'b0;
   // one pulse, never shorter than two clocks
   task automatic pulse(input int hiClks);
      @(posedge ref_clk);
      extTrigger <= 1'b1;
      repeat ((hiClks < 2) ? 2 : hiClks) @(posedge ref_clk);
      extTrigger <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the rolling-shutter trigger sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end
module testbench;
   localparam int R = 4;
   localparam int F = 4;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [3:0]  regAddr = 4'h0;
   logic [31:0] regWrData = 32'h0;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic [31:0] regRdData;
   logic        extTrigger;
   logic [8:0]  so;
   int          err_total = 0;
   int          checks_done = 0;
   int          cyc = 0;
   int          n;
   int          t0;
   // clock and cycle count
   initial forever #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;
   rs_trigger_sequencer #(.ROW_CLKS(R), .FRAME_ROWS(F)) i_rs_trigger_sequencer
   (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .extTrigger(extTrigger),
      .seqOut(so)
   );
   trig_source i_trig_source (.ref_clk(ref_clk), .extTrigger(extTrigger));
   // combined exposure outputs follow row-1 and row-n
   always @(negedge ref_clk)
   begin
      if (!sys_rst)
      begin
         `CHK("fireAll", so[8] & so[7], so[6])
         `CHK("fireAny", 1'b1, so[5] | ~(so[8] | so[7]))
      end
   end
   // register bus cycles
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= v;
      @(posedge ref_clk);
      regWr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1;
      `CHK("regRdData", e, regRdData)
   endtask
   // count cycles while an output bit holds a level
   task automatic cnt(input int b, input logic v, output int k);
      k = 0;
      while (so[b] === v && k < 2000)
      begin
         @(posedge ref_clk);
         #1;
         k++;
      end
   endtask
   task automatic wait_for(input int b, input logic v);
      int k;
      cnt(b, ~v, k);
      `CHK("wait level", v, so[b])
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      end_of_test();
   end
   // test sequence
   initial
   begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      #1;
      `CHK("reset outputs", 9'h010, so)
      rd(4'h1, 32'h0000_000a);
      rd(4'h2, 32'h0000_0800);
      rd(4'hf, 32'h0000_0000);
      $display("test reset done");
      wr(4'h1, 32'h0000_0003);
      wr(4'h0, 32'h0000_0005);
      wait_for(0, 1'b1);
      `CHK("armed", 9'h019, so & 9'h019)
      rd(4'h3, 32'h0000_0208);
      wr(4'h0, 32'h0000_0015);
      wait_for(8, 1'b1);
      `CHK("trigger start", 9'h104, so & 9'h11d)
      cnt(8, 1'b1, n);
      `CHK("exposure", 3 * R, n)
      `CHK("signal read", 1'b1, so[1])
      i_trig_source.pulse(4);
      wait_for(0, 1'b1);
      `CHK("flush", 1'b1, so[4])
      repeat (16) @(posedge ref_clk);
      #1;
      `CHK("ignored trigger", 9'h019, so & 9'h01d)
      i_trig_source.pulse(4);
      wait_for(2, 1'b1);
      wait_for(0, 1'b1);
      $display("test triggered done");
      wr(4'h0, 32'h0000_0000);
      wr(4'h0, 32'h0000_0009);
      wait_for(0, 1'b1);
      fork
         i_trig_source.pulse(6 * R);
         begin wait_for(8, 1'b1); cnt(8, 1'b1, n); end
      join
      `CHK("pulse exposure", 6 * R, n)
      `CHK("signal at fall", 1'b1, so[1])
      cnt(7, 1'b1, n);
      `CHK("last row end", (F - 1) * R, n)
      wait_for(0, 1'b1);
      fork
         begin i_trig_source.pulse(2 * R); repeat (12) @(posedge ref_clk); i_trig_source.pulse(4 * R); end
         begin wait_for(8, 1'b1); cnt(8, 1'b1, n); end
      join
      `CHK("short fall", 2 * R + 12 + 1 + 4 * R, n)
      wait_for(0, 1'b1);
      $display("test external exposure done");
      wr(4'h0, 32'h0000_0000);
      wr(4'h1, 32'h0000_0001);
      wr(4'h2, 32'h0000_000c);
      wr(4'h0, 32'h0000_0001);
      wait_for(2, 1'b1);
      t0 = cyc;
      `CHK("flush release", 9'h104, so & 9'h114)
      cnt(8, 1'b1, n);
      `CHK("one row exposure", R, n)
      wait_for(4, 1'b1);
      wait_for(2, 1'b1);
      `CHK("cycle time", 12 * R, cyc - t0)
      $display("test internal done");
      for (int i = 0; i < 2; i++)
      begin
         wr(4'h0, 32'h0000_0000);
         wr(4'h1, i ? 32'h0000_0006 : 32'h0000_0002);
         wr(4'h0, 32'h0000_0003);
         wait_for(8, 1'b1);
         wait_for(8, 1'b0);
         wait_for(8, 1'b1);
         t0 = cyc;
         `CHK("overlap readout", 1'b1, so[1] | so[2])
         wait_for(8, 1'b0);
         wait_for(8, 1'b1);
         `CHK("overlap cycle", (i ? 7 : F) * R, cyc - t0)
      end
      wr(4'h0, 32'h0000_0000);
      $display("test overlap done");
      wr(4'h0, 32'h0000_000b);
      wait_for(0, 1'b1);
      i_trig_source.pulse(4);
      wait_for(2, 1'b1);
      wait_for(8, 1'b1);
      fork
         i_trig_source.pulse(4);
         begin
            wait_for(8, 1'b0);
            `CHK("overlap signal", 1'b1, so[1])
            cnt(8, 1'b0, n);
         end
      join
      `CHK("row-1 low gap", 20, n)
      wr(4'h0, 32'h0000_0000);
      $display("test external overlap done");
      end_of_test();
   end
endmodule
`default_nettype wire
